// ### hdl/cib_defs.svh
// Operation
// - Index port at 3F0H or 370H, config mode
// - Index selects register at data port 3F1H/371H
// - Power-up defaults; hard reset keeps registers except the lock bit
// - Register 00H reachable in config mode, 28H
// - Bits 1:0 choose disk or alternate IR
// - Code 0x enables disk pin pull-ups
// - Code 11 drives extra IRQ, alternate IR
// - Code 10 drives disk enable and selects
// - Register 00H reserved bits read 0,1
// - Bit 3 low puts floppy in low power
// - Valid bit is storage only, resets 0
// - Register 01H reachable in config mode, 9CH
// - Register 01H reserved bits read fixed values
// - Bit 2 low puts parallel port low power
// - Lock cleared stays clear until hard reset
`ifndef CIB_DEFS_SVH
`define CIB_DEFS_SVH

`define CIB_INDEX_PORT 10'h3f0
`define CIB_INDEX_PORT_ALT 10'h370
`define CIB_DATA_PORT 10'h3f1
`define CIB_DATA_PORT_ALT 10'h371

`define CIB_IDX_PFN 8'h00
`define CIB_IDX_PPL 8'h01
`define CIB_LOCK_LIMIT 8'h0f

`define CIB_PFN_RESET 8'h28
`define CIB_PFN_WR_MASK 8'h8b
`define CIB_PFN_ONES 8'h20
`define CIB_PFN_SEL_LSB 0
`define CIB_PFN_SEL_MSB 1
`define CIB_PFN_FDC_PWR 3
`define CIB_PFN_VALID 7

`define CIB_PPL_RESET 8'h9c
`define CIB_PPL_WR_MASK 8'h8c
`define CIB_PPL_ONES 8'h10
`define CIB_PPL_PP_PWR 2
`define CIB_PPL_PP_MODE 3
`define CIB_PPL_LOCK 7

`define CIB_PIN_W 23
`define CIB_PIN_IDLE 23'h5c0000
`define CIB_PIN_HRST_N 22
`define CIB_PIN_AEN 21
`define CIB_PIN_RD_N 20
`define CIB_PIN_WR_N 19
`define CIB_PIN_IR_RX 18
`define CIB_PIN_ADDR_LSB 8
`define CIB_PIN_ADDR_MSB 17
`define CIB_PIN_DATA_LSB 0
`define CIB_PIN_DATA_MSB 7

`endif

// ### hdl/cib_pkg.sv
package cib_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10
	} cib_bus_t;

	typedef enum logic [1:0] {
		PFN_OFF = 2'b00,
		PFN_RSVD = 2'b01,
		PFN_DISK = 2'b10,
		PFN_ALT_IR = 2'b11
	} cib_pfn_t;

endpackage

// ### hdl/cib_bank.sv
`timescale 1ns/10ps
`include "cib_defs.svh"

module cib_bank (
	// Clock and power-up reset
	input wire logic clock,
	input wire logic rst_n,
	// Hard reset pin, only returns the lock bit
	input wire logic hard_reset_n,
	// Configuration mode from the entry/exit sequencer
	input wire logic config_mode,
	input wire logic alt_base,
	// I/O bus pins
	input wire logic [9:0] io_addr,
	input wire logic io_aen,
	input wire logic io_rd_n,
	input wire logic io_wr_n,
	input wire logic [7:0] io_data_in,
	output logic [7:0] io_data_out,
	output logic io_data_oe_n,
	// Disk interface decode hits
	input wire logic disk_cs0_hit,
	input wire logic disk_cs1_hit,
	// Disk interface pins
	output logic disk_iface_enable_n,
	output logic disk_iface_enable_oe_n,
	output logic disk_chip_select0_n,
	output logic disk_chip_select0_oe_n,
	output logic disk_chip_select1_n,
	output logic disk_chip_select1_oe_n,
	output logic disk_pullup_en,
	// Extra interrupt and alternate infrared pins
	input wire logic irq_extra_in,
	input wire logic ir_tx_in,
	input wire logic alt_infrared_receive,
	output logic irq_extra_out,
	output logic irq_extra_oe_n,
	output logic alt_infrared_transmit,
	output logic alt_ir_tx_oe_n,
	output logic alt_ir_rx_data,
	output logic alt_ir_pullup_en,
	// Function controls and status
	output cib_pkg::cib_pfn_t pin_function,
	output logic floppy_low_power,
	output logic parport_low_power,
	output logic parport_printer_mode,
	output logic config_locked
);
	import cib_pkg::*;

	// Pin synchroniser stages
	logic [`CIB_PIN_W-1:0] pin_raw;
	logic [`CIB_PIN_W-1:0] pin_s1;
	logic [`CIB_PIN_W-1:0] pin_s2;
	logic [`CIB_PIN_W-1:0] pin_s3;
	logic [`CIB_PIN_W-1:0] pin_q;

	// Filtered bus view
	logic [9:0] bus_addr;
	logic [7:0] bus_data;
	logic bus_aen;
	logic bus_rd;
	logic bus_wr;
	logic hard_rst;

	// Bus cycle tracking
	cib_bus_t bus_state;
	cib_bus_t next_bus_state;
	logic [9:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_commit;

	// Configuration storage
	logic [7:0] index_reg;
	logic [7:0] pfn_reg;
	logic [7:0] ppl_reg;

	// Decode
	logic hit_index_w;
	logic hit_data_w;
	logic hit_data_r;
	logic sel_blocked;
	logic sel_pfn;
	logic sel_ppl;
	logic rd_hit;
	logic [7:0] rd_value;
	logic [1:0] pfn_code;
	logic wr_lock_bit;

	assign pin_raw = {hard_reset_n, io_aen, io_rd_n, io_wr_n,
		alt_infrared_receive, io_addr, io_data_in};

	// Three stages; the first stage feeds only the second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_s1 <= `CIB_PIN_IDLE;
			pin_s2 <= `CIB_PIN_IDLE;
			pin_s3 <= `CIB_PIN_IDLE;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Per-bit idle levels, so reset shows no false strobe
	localparam logic [`CIB_PIN_W-1:0] pin_idle_lvl = `CIB_PIN_IDLE;

	// A bit moves only once the last two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < `CIB_PIN_W; gi = gi + 1) begin : g_filt
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					pin_q[gi] <= pin_idle_lvl[gi];
				end else if (pin_s2[gi] == pin_s3[gi]) begin
					pin_q[gi] <= pin_s3[gi];
				end
			end
		end
	endgenerate

	assign bus_addr = pin_q[`CIB_PIN_ADDR_MSB:`CIB_PIN_ADDR_LSB];
	assign bus_data = pin_q[`CIB_PIN_DATA_MSB:`CIB_PIN_DATA_LSB];
	assign bus_aen = pin_q[`CIB_PIN_AEN];
	assign bus_rd = !pin_q[`CIB_PIN_RD_N] && !bus_aen;
	assign bus_wr = !pin_q[`CIB_PIN_WR_N] && !bus_aen;
	assign hard_rst = !pin_q[`CIB_PIN_HRST_N];

	// Port decode follows the selected base
	always_comb begin
		if (alt_base) begin
			hit_index_w = (wr_addr == `CIB_INDEX_PORT_ALT);
			hit_data_w = (wr_addr == `CIB_DATA_PORT_ALT);
			hit_data_r = (bus_addr == `CIB_DATA_PORT_ALT);
		end else begin
			hit_index_w = (wr_addr == `CIB_INDEX_PORT);
			hit_data_w = (wr_addr == `CIB_DATA_PORT);
			hit_data_r = (bus_addr == `CIB_DATA_PORT);
		end
	end

	// Lower registers vanish while locked
	assign sel_blocked = !ppl_reg[`CIB_PPL_LOCK] &&
		(index_reg <= `CIB_LOCK_LIMIT);
	assign sel_pfn = (index_reg == `CIB_IDX_PFN) && !sel_blocked;
	assign sel_ppl = (index_reg == `CIB_IDX_PPL) && !sel_blocked;

	// Bus cycle state; a write commits when its strobe ends
	always_comb begin
		next_bus_state = bus_state;
		wr_commit = 1'b0;
		case (bus_state)
			BUS_IDLE: begin
				if (bus_wr) begin
					next_bus_state = BUS_WRITE;
				end else if (bus_rd) begin
					next_bus_state = BUS_READ;
				end
			end
			BUS_WRITE: begin
				if (!bus_wr) begin
					next_bus_state = BUS_IDLE;
					wr_commit = config_mode;
				end
			end
			BUS_READ: begin
				if (!bus_rd) begin
					next_bus_state = BUS_IDLE;
				end
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Data may settle late in the strobe, so the last sample wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_addr <= 10'h000;
			wr_data <= 8'h00;
		end else if (bus_state == BUS_WRITE && bus_wr) begin
			wr_addr <= bus_addr;
			wr_data <= bus_data;
		end
	end

	// Index register, write only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			index_reg <= 8'h00;
		end else if (wr_commit && hit_index_w) begin
			index_reg <= wr_data;
		end
	end

	// Register 00H; rst_n is the power-up reset only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pfn_reg <= `CIB_PFN_RESET;
		end else if (wr_commit && hit_data_w && sel_pfn) begin
			pfn_reg <= wr_data & `CIB_PFN_WR_MASK;
		end
	end

	// Lock bit may only fall by software
	assign wr_lock_bit = wr_data[`CIB_PPL_LOCK] &
		ppl_reg[`CIB_PPL_LOCK];

	// Register 01H; hard reset touches only the lock bit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ppl_reg <= `CIB_PPL_RESET;
		end else begin
			if (wr_commit && hit_data_w && sel_ppl) begin
				ppl_reg[`CIB_PPL_PP_PWR] <= wr_data[`CIB_PPL_PP_PWR];
				ppl_reg[`CIB_PPL_PP_MODE] <= wr_data[`CIB_PPL_PP_MODE];
				ppl_reg[`CIB_PPL_LOCK] <= wr_lock_bit;
			end
			// Hard reset wins over a same-cycle software clear
			if (hard_rst) begin
				ppl_reg[`CIB_PPL_LOCK] <= 1'b1;
			end
		end
	end

	// Read value with fixed reserved bits
	always_comb begin
		rd_value = 8'h00;
		if (sel_pfn) begin
			rd_value = (pfn_reg & `CIB_PFN_WR_MASK) | `CIB_PFN_ONES;
		end else if (sel_ppl) begin
			rd_value = (ppl_reg & `CIB_PPL_WR_MASK) | `CIB_PPL_ONES;
		end
	end

	// Unknown or blocked indices leave the bus undriven
	assign rd_hit = bus_rd && config_mode && hit_data_r &&
		(sel_pfn || sel_ppl);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			io_data_out <= 8'h00;
			io_data_oe_n <= 1'b1;
		end else begin
			io_data_out <= rd_value;
			io_data_oe_n <= !rd_hit;
		end
	end

	assign pfn_code = pfn_reg[`CIB_PFN_SEL_MSB:`CIB_PFN_SEL_LSB];

	// Pin function select; reserved code is reported as PFN_RSVD, pins act as off
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_function <= PFN_OFF;
		end else begin
			pin_function <= cib_pfn_t'(pfn_code);
		end
	end

	// Disk interface pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			disk_iface_enable_n <= 1'b1;
			disk_iface_enable_oe_n <= 1'b1;
			disk_chip_select0_n <= 1'b1;
			disk_chip_select0_oe_n <= 1'b1;
			disk_chip_select1_n <= 1'b1;
			disk_chip_select1_oe_n <= 1'b1;
			disk_pullup_en <= 1'b1;
		end else begin
			disk_pullup_en <= !pfn_code[1];
			if (pfn_code == PFN_DISK) begin
				disk_iface_enable_n <= !(disk_cs0_hit || disk_cs1_hit);
				disk_chip_select0_n <= !disk_cs0_hit;
				disk_chip_select1_n <= !disk_cs1_hit;
				disk_iface_enable_oe_n <= 1'b0;
				disk_chip_select0_oe_n <= 1'b0;
				disk_chip_select1_oe_n <= 1'b0;
			end else begin
				disk_iface_enable_n <= 1'b1;
				disk_chip_select0_n <= 1'b1;
				disk_chip_select1_n <= 1'b1;
				disk_iface_enable_oe_n <= 1'b1;
				disk_chip_select0_oe_n <= 1'b1;
				disk_chip_select1_oe_n <= 1'b1;
			end
		end
	end

	// Extra interrupt and alternate infrared pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_extra_out <= 1'b0;
			irq_extra_oe_n <= 1'b1;
			alt_infrared_transmit <= 1'b0;
			alt_ir_tx_oe_n <= 1'b1;
			alt_ir_rx_data <= 1'b1;
			alt_ir_pullup_en <= 1'b1;
		end else if (pfn_code == PFN_ALT_IR) begin
			irq_extra_out <= irq_extra_in;
			irq_extra_oe_n <= 1'b0;
			alt_infrared_transmit <= ir_tx_in;
			alt_ir_tx_oe_n <= 1'b0;
			alt_ir_rx_data <= pin_q[`CIB_PIN_IR_RX];
			alt_ir_pullup_en <= 1'b0;
		end else begin
			// Receive idles high so the infrared core sees no edge
			irq_extra_out <= 1'b0;
			irq_extra_oe_n <= 1'b1;
			alt_infrared_transmit <= 1'b0;
			alt_ir_tx_oe_n <= 1'b1;
			alt_ir_rx_data <= 1'b1;
			alt_ir_pullup_en <= 1'b1;
		end
	end

	// Power and mode controls; the valid bit drives nothing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			floppy_low_power <= 1'b0;
			parport_low_power <= 1'b0;
			parport_printer_mode <= 1'b1;
			config_locked <= 1'b0;
		end else begin
			floppy_low_power <= !pfn_reg[`CIB_PFN_FDC_PWR];
			parport_low_power <= !ppl_reg[`CIB_PPL_PP_PWR];
			parport_printer_mode <= ppl_reg[`CIB_PPL_PP_MODE];
			config_locked <= !ppl_reg[`CIB_PPL_LOCK];
		end
	end

endmodule // cib_bank

// ### verif/cib_bank_sva.sv
`timescale 1ns/10ps
module cib_bank_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host side
	input wire logic hard_reset_n,
	input wire logic config_mode,
	input wire logic io_rd_n,
	input wire logic io_wr_n,
	input wire logic io_data_oe_n,
	// Pin side
	input wire logic irq_extra_in,
	input wire logic disk_iface_enable_oe_n,
	input wire logic disk_chip_select0_oe_n,
	input wire logic disk_pullup_en,
	input wire logic irq_extra_out,
	input wire logic irq_extra_oe_n,
	input wire logic alt_ir_tx_oe_n,
	input wire logic alt_ir_pullup_en,
	// Pins checked against their sources
	input wire logic disk_cs0_hit,
	input wire logic disk_cs1_hit,
	input wire logic ir_tx_in,
	input wire logic disk_iface_enable_n,
	input wire logic disk_chip_select0_n,
	input wire logic disk_chip_select1_n,
	input wire logic disk_chip_select1_oe_n,
	input wire logic alt_infrared_transmit,
	input wire logic alt_ir_rx_data,
	// Status
	input wire cib_pkg::cib_pfn_t pin_function,
	input wire logic floppy_low_power,
	input wire logic parport_low_power,
	input wire logic parport_printer_mode,
	input wire logic config_locked
);
	import cib_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Derived pins lag the code, so judge only a settled code
	sequence pf_held;
		pin_function == $past(pin_function) &&
			pin_function == $past(pin_function, 2);
	endsequence
	AST_PULLUP: assert property (pf_held |->
		disk_pullup_en == !pin_function[1])
		else $error("disk pull-up wrong");
	AST_DISK_DRIVE: assert property (pf_held |->
		disk_iface_enable_oe_n == (pin_function != PFN_DISK) &&
		disk_chip_select0_oe_n == (pin_function != PFN_DISK))
		else $error("disk pin drive wrong");
	AST_ALT_IR: assert property (pf_held |->
		alt_ir_pullup_en == (pin_function != PFN_ALT_IR) &&
		alt_ir_tx_oe_n == alt_ir_pullup_en &&
		irq_extra_oe_n == alt_ir_pullup_en)
		else $error("alternate pin drive wrong");
	AST_IRQ_ROUTE: assert property (pf_held ##0
		pin_function == PFN_ALT_IR |-> irq_extra_out == $past(irq_extra_in))
		else $error("extra interrupt not routed");
	AST_NO_DRIVE_OUT: assert property (!config_mode |=> io_data_oe_n)
		else $error("data driven outside mode");
	AST_LOCK_HIDES: assert property (config_locked |-> io_data_oe_n)
		else $error("data driven while locked");
	AST_READ_RELEASE: assert property ($rose(io_rd_n) |->
		##[4:5] io_data_oe_n)
		else $error("read data not released");
	AST_LOCK_STICKY: assert property (hard_reset_n[*6] ##0
		config_locked |=> config_locked)
		else $error("lock bit came back");
	AST_QUIET: assert property (io_wr_n[*8] |->
		$stable(floppy_low_power) && $stable(parport_low_power) &&
		$stable(parport_printer_mode) && $stable(pin_function))
		else $error("state changed with no write");
	AST_DISK_SELECT: assert property (pf_held ##0
		pin_function == PFN_DISK |->
		disk_chip_select0_n == !$past(disk_cs0_hit) &&
		disk_chip_select1_n == !$past(disk_cs1_hit) &&
		disk_iface_enable_n ==
		!($past(disk_cs0_hit) || $past(disk_cs1_hit)))
		else $error("disk select not driven");
	AST_DISK_IDLE: assert property (pin_function != PFN_DISK |->
		disk_iface_enable_n && disk_chip_select0_n &&
		disk_chip_select1_n && disk_chip_select1_oe_n)
		else $error("disk pins active when off");
	AST_ALT_TX: assert property (pf_held ##0
		pin_function == PFN_ALT_IR |->
		alt_infrared_transmit == $past(ir_tx_in))
		else $error("alternate transmit not routed");
	AST_ALT_IDLE: assert property (pin_function != PFN_ALT_IR |->
		alt_ir_rx_data && !alt_infrared_transmit && !irq_extra_out)
		else $error("alternate pins active when off");
	cover property (pin_function == PFN_ALT_IR);
	cover property (pin_function == PFN_DISK);
	cover property (config_locked);
	cover property (!io_data_oe_n);
endmodule // cib_bank_sva

bind cib_bank cib_bank_sva sva_u (.clock, .rst_n, .hard_reset_n,
	.config_mode, .io_rd_n, .io_wr_n, .io_data_oe_n, .irq_extra_in,
	.disk_iface_enable_oe_n, .disk_chip_select0_oe_n, .disk_pullup_en,
	.irq_extra_out, .irq_extra_oe_n, .alt_ir_tx_oe_n, .alt_ir_pullup_en,
	.disk_cs0_hit, .disk_cs1_hit, .ir_tx_in, .disk_iface_enable_n,
	.disk_chip_select0_n, .disk_chip_select1_n, .disk_chip_select1_oe_n,
	.alt_infrared_transmit, .alt_ir_rx_data,
	.pin_function, .floppy_low_power, .parport_low_power,
	.parport_printer_mode, .config_locked);

// ### verif/cib_host.sv
`timescale 1ns/10ps
`include "cib_defs.svh"
module cib_host (
	// Clock and base select
	input wire logic clock,
	input wire logic alt_base,
	// Bus pins toward the device
	output logic [9:0] io_addr,
	output logic io_aen,
	output logic io_rd_n,
	output logic io_wr_n,
	output logic [7:0] io_data_in,
	// Device answer
	input wire logic [7:0] io_data_out,
	input wire logic io_data_oe_n
);
	initial begin
		io_addr = 10'h000;
		io_aen = 1'b1;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		io_data_in = 8'h00;
	end
	// Strobe low and high 8 cycles: well past the 3-flop filters
	task automatic cyc(input logic rd, input logic a, input logic [7:0] d,
		output logic [7:0] q, output logic drv);
		@(negedge clock);
		io_addr = (alt_base ? `CIB_INDEX_PORT_ALT : `CIB_INDEX_PORT) + 10'(a);
		io_data_in = d;
		io_aen = 1'b0;
		if (rd) io_rd_n = 1'b0;
		else io_wr_n = 1'b0;
		repeat (8) @(negedge clock);
		q = io_data_out;
		drv = !io_data_oe_n;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		repeat (8) @(negedge clock);
		// Released bus shows a changed pattern, never the old value
		io_aen = 1'b1;
		io_addr = ~io_addr;
		io_data_in = ~io_data_in;
	endtask
endmodule // cib_host

// ### verif/cib_bank_tb_top.sv
`timescale 1ns/10ps
module cib_bank_tb_top;
	import cib_pkg::*;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [2:0] st;
	} cib_row_t;
	cib_row_t rows [8] = '{'{8'h00, 8'hff, 8'hab, 3'b001},
		'{8'h00, 8'h00, 8'h20, 3'b101}, '{8'h00, 8'h01, 8'h21, 3'b101},
		'{8'h00, 8'h02, 8'h22, 3'b101}, '{8'h00, 8'h8b, 8'hab, 3'b001},
		'{8'h01, 8'h80, 8'h90, 3'b010}, '{8'h01, 8'hff, 8'h9c, 3'b001},
		'{8'h00, 8'h28, 8'h28, 3'b001}};
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hard_reset_n = 1'b1;
	logic config_mode = 1'b1;
	logic alt_base = 1'b1;
	logic [4:0] misc = 5'h00;
	logic [9:0] io_addr;
	logic io_aen, io_rd_n, io_wr_n, io_data_oe_n, drv;
	logic [7:0] io_data_in, io_data_out, q;
	logic [1:0] pf = 2'b00;
	cib_pfn_t pin_function;
	logic floppy_low_power, parport_low_power, parport_printer_mode;
	logic config_locked;
	int error_cnt = 0;
	int comparisons = 0;

	always #10 clock = ~clock;
	always @(negedge clock) misc <= misc + 5'h01;

	cib_host host_u (.clock, .alt_base, .io_addr, .io_aen, .io_rd_n,
		.io_wr_n, .io_data_in, .io_data_out, .io_data_oe_n);
	cib_bank dut_u (.clock, .rst_n, .hard_reset_n, .config_mode, .alt_base,
		.io_addr, .io_aen, .io_rd_n, .io_wr_n, .io_data_in, .io_data_out,
		.io_data_oe_n, .disk_cs0_hit(misc[0]), .disk_cs1_hit(misc[1]),
		.disk_iface_enable_n(), .disk_iface_enable_oe_n(),
		.disk_chip_select0_n(), .disk_chip_select0_oe_n(),
		.disk_chip_select1_n(), .disk_chip_select1_oe_n(),
		.disk_pullup_en(), .irq_extra_in(misc[2]), .ir_tx_in(misc[3]),
		.alt_infrared_receive(misc[4]), .irq_extra_out(), .irq_extra_oe_n(),
		.alt_infrared_transmit(), .alt_ir_tx_oe_n(), .alt_ir_rx_data(),
		.alt_ir_pullup_en(), .pin_function, .floppy_low_power,
		.parport_low_power, .parport_printer_mode, .config_locked);

	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Index first, then data port
	task automatic reg_rd(input logic [7:0] idx);
		host_u.cyc(1'b0, 1'b0, idx, q, drv);
		host_u.cyc(1'b1, 1'b1, 8'h00, q, drv);
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		host_u.cyc(1'b0, 1'b0, idx, q, drv);
		host_u.cyc(1'b0, 1'b1, d, q, drv);
	endtask
	task automatic conclude;
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		conclude;
	end

	initial begin
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		reg_rd(8'h00);
		chk("reg00 default", q, 8'h28);
		reg_rd(8'h01);
		chk("reg01 default", q, 8'h9c);
		alt_base = 1'b0;
		for (int i = 0; i < 8; i++) begin
			reg_wr(rows[i].idx, rows[i].wd);
			if (rows[i].idx == 8'h00) pf = rows[i].wd[1:0];
			reg_rd(rows[i].idx);
			chk("readback", q, rows[i].rd);
			chk("power mode", {5'h00, floppy_low_power, parport_low_power,
				parport_printer_mode}, {5'h00, rows[i].st});
			chk("pin function", {6'h00, pin_function}, {6'h00, pf});
		end
		host_u.cyc(1'b1, 1'b0, 8'h00, q, drv);
		chk("index port read", {7'h00, drv}, 8'h00);
		reg_rd(8'h02);
		chk("unmapped read", {7'h00, drv}, 8'h00);
		config_mode = 1'b0;
		reg_wr(8'h00, 8'h03);
		config_mode = 1'b1;
		reg_rd(8'h00);
		chk("outside mode", q, 8'h28);
		reg_wr(8'h01, 8'h10);
		chk("locked", {7'h00, config_locked}, 8'h01);
		reg_rd(8'h00);
		chk("locked read", {7'h00, drv}, 8'h00);
		reg_wr(8'h00, 8'h03);
		reg_wr(8'h01, 8'h9c);
		chk("lock sticky", {7'h00, config_locked}, 8'h01);
		hard_reset_n = 1'b0;
		repeat (6) @(negedge clock);
		hard_reset_n = 1'b1;
		repeat (8) @(negedge clock);
		chk("hard reset lock", {7'h00, config_locked}, 8'h00);
		reg_rd(8'h00);
		chk("reg00 kept", q, 8'h28);
		reg_rd(8'h01);
		chk("reg01 kept", q, 8'h90);
		conclude;
	end
endmodule // cib_bank_tb_top
